/* include/tbm_regs.svh */
/*
  Register offsets, field positions and reset values of the two-wire bus master.
  Assumes byte addresses on an 8-bit APB address, one 32-bit word per register.
*/
`ifndef TBM_REGS_SVH
`define TBM_REGS_SVH

`define TBM_OFF_CTRL       8'h00
`define TBM_OFF_CWG        8'h04
`define TBM_OFF_CMD        8'h08
`define TBM_OFF_NCMD       8'h0C
`define TBM_OFF_RHR        8'h10
`define TBM_OFF_THR        8'h14
`define TBM_OFF_SR         8'h18
`define TBM_OFF_IER        8'h1C
`define TBM_OFF_IDR        8'h20
`define TBM_OFF_IMR        8'h24
`define TBM_OFF_SCR        8'h28

`define TBM_CTRL_EN        0
`define TBM_CTRL_SWRST     7

`define TBM_CWG_LOW_LSB    0
`define TBM_CWG_HIGH_LSB   8
`define TBM_CWG_START_STOP_COUNT_LSB 16
`define TBM_CWG_DATA_LSB   24
`define TBM_CWG_EXP_LSB    28

`define TBM_CMD_READ       0
`define TBM_CMD_TARGET_ADDRESS_LSB   1
`define TBM_CMD_START      13
`define TBM_CMD_STOP       14
`define TBM_CMD_VALID      15
`define TBM_CMD_NB_LSB     16

`define TBM_SR_RX_READY_FLAG       0
`define TBM_SR_TX_READY_FLAG       1
`define TBM_SR_CMD_SLOT_READY        2
`define TBM_SR_COMMAND_DONE_FLAG       3
`define TBM_SR_BUS_IDLE_FLAG     4
`define TBM_SR_ADDR_NACK_FLAG        8
`define TBM_SR_DATA_NACK_FLAG        9
`define TBM_SR_ARB_LOST_FLAG      10
`define TBM_SR_W           11

`define TBM_RST_CWG        32'h0000_0000
`define TBM_RST_IMR        11'h000

`endif

/* include/tbm_pkg.sv */
/*
  Types of the two-wire bus master: engine phases, command word, full state.
  Assumes tbm_regs.svh on the include path.
*/
`include "tbm_regs.svh"
package tbm_pkg;

  typedef enum logic [3:0] {
    S_IDLE   = 4'h0,
    S_START  = 4'h1,
    S_STHOLD = 4'h2,
    S_LOW    = 4'h3,
    S_HIGH   = 4'h4,
    S_HOLD   = 4'h5,
    S_RSTAL  = 4'h6,
    S_STOPL  = 4'h7,
    S_STOPH  = 4'h8,
    S_BUF    = 4'h9,
    S_ARBW   = 4'hA
  } tbm_phase_t;

  typedef struct packed {
    logic       valid;
    logic       stop;
    logic       start;
    logic [7:0] byte_count;
    logic [6:0] target_address;
    logic       read;
  } tbm_cmd_t;

  typedef struct packed {
    tbm_phase_t            st;
    logic [8:0]            pre;
    logic [9:0]            cnt;
    logic [3:0]            bitCnt;
    logic [7:0]            sh;
    logic                  addrPh;
    logic                  gotByte;
    logic                  sclOen;
    logic                  sdaOen;
    logic                  sclM;
    logic                  sclS;
    logic                  sdaM;
    logic                  sdaS;
    logic                  sdaP;
    logic                  busy;
    logic                  en;
    logic                  irq;
    logic [31:0]           cwg;
    tbm_cmd_t              cmd;
    tbm_cmd_t              ncmd;
    logic [7:0]            tx_holding_reg;
    logic                  txValid;
    logic [7:0]            rx_holding_reg;
    logic                  rxValid;
    logic                  command_done_flag;
    logic                  addr_nack_flag;
    logic                  data_nack_flag;
    logic                  arbl;
    logic [`TBM_SR_W-1:0]  imr;
    logic [31:0]           prdata;
  } tbm_state_t;

endpackage : tbm_pkg

/* verilog/tbm_two_wire_master.sv */
/*
  Two-wire bus master: APB register file, command engine, bit timing and
  open-drain line control, with DMA requests and one interrupt line.
  Assumes external pull-ups on both lines; the surrounding pad logic turns
  each output enable into a wired-AND line.
*/
// Notes on behaviour
// - Lines only pulled low or released
// - Eight-bit bytes, MSB first, then acknowledge
// - START and STOP change data while clock high
// - Prescaled tick is clock over 2^(exp+1)
// - Low, high, start/stop, data counts time bus
// - Clock low lasts hold plus setup plus low
// - Counters start on the sensed clock level
// - Report bus free and command slot ready
// - No new transfer while error flags set
// - After NACK send STOP, keep command valid
// - Pending transmit byte goes out next transfer
// - Idle bus, start, write: START and address
// - Address ninth pulse sampled; set address NACK
// - Transmit waits for holding data, then counts down
// - Zero-byte start/stop command: START, address, STOP
// - Data ack sampled; set data NACK flag
// - Ready flags drive the DMA requests
// - Command done flag when a command finishes
// - Idle bus, start, read: START and address
// - Receive waits for empty holding register
// - Acknowledge every received byte except last
// - Lost arbitration: release, flag, wait for STOP
// - Busy bus: wait for STOP before START
`timescale 1ns/1ps
`include "tbm_regs.svh"
module tbm_two_wire_master
  import tbm_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial clock line
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOen,
  // Serial data line
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOen,
  // DMA handshake and interrupt
  output logic             dmaTxReq,
  output logic             dmaRxReq,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Encoding and decoding helpers

  function automatic tbm_cmd_t cmdDecode(input logic [31:0] w);
    tbm_cmd_t c;
    c.read   = w[`TBM_CMD_READ];
    c.target_address   = w[`TBM_CMD_TARGET_ADDRESS_LSB +: 7];
    c.start  = w[`TBM_CMD_START];
    c.stop   = w[`TBM_CMD_STOP];
    c.valid  = w[`TBM_CMD_VALID];
    c.byte_count = w[`TBM_CMD_NB_LSB +: 8];
    return c;
  endfunction : cmdDecode

  function automatic logic [31:0] cmdEncode(input tbm_cmd_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`TBM_CMD_READ]            = c.read;
    w[`TBM_CMD_TARGET_ADDRESS_LSB +: 7]   = c.target_address;
    w[`TBM_CMD_START]           = c.start;
    w[`TBM_CMD_STOP]            = c.stop;
    w[`TBM_CMD_VALID]           = c.valid;
    w[`TBM_CMD_NB_LSB +: 8]     = c.byte_count;
    return w;
  endfunction : cmdEncode

  function automatic logic regKnown(input logic [7:0] a);
    case (a)
      `TBM_OFF_CTRL, `TBM_OFF_CWG, `TBM_OFF_CMD, `TBM_OFF_NCMD,
      `TBM_OFF_RHR, `TBM_OFF_THR, `TBM_OFF_SR, `TBM_OFF_IER,
      `TBM_OFF_IDR, `TBM_OFF_IMR, `TBM_OFF_SCR: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : regKnown

  ////////////////////////////////////////////////////////////////////////////
  // State and derived values

  tbm_state_t           r_ff;
  tbm_state_t           nxt_r;
  logic [8:0]           preLim;
  logic                 tick;
  logic [9:0]           dataT;
  logic [9:0]           lowT;
  logic [9:0]           highT;
  logic [9:0]           stastoT;
  logic [9:0]           lowEnd;
  logic                 txMode;
  logic                 lastRx;
  logic                 bitVal;
  logic                 errs;
  logic                 startDet;
  logic                 stopDet;
  logic                 wrEn;
  logic                 rdEn;
  logic [`TBM_SR_W-1:0] status;
  logic [31:0]          rdMux;

  assign preLim  = (9'h002 << r_ff.cwg[`TBM_CWG_EXP_LSB +: 3]) - 9'h001;
  assign tick    = (r_ff.pre == preLim);
  assign dataT   = {6'h00, r_ff.cwg[`TBM_CWG_DATA_LSB +: 4]};
  assign lowT    = {2'b00, r_ff.cwg[`TBM_CWG_LOW_LSB +: 8]};
  assign highT   = {2'b00, r_ff.cwg[`TBM_CWG_HIGH_LSB +: 8]};
  assign stastoT = {2'b00, r_ff.cwg[`TBM_CWG_START_STOP_COUNT_LSB +: 8]};
  assign lowEnd  = (dataT << 1) + lowT;
  assign txMode  = r_ff.addrPh | ~r_ff.cmd.read;
  assign lastRx  = (r_ff.cmd.byte_count == 8'h01);
  assign errs    = r_ff.addr_nack_flag | r_ff.data_nack_flag | r_ff.arbl;
  assign startDet = r_ff.sclS & r_ff.sdaP & ~r_ff.sdaS;
  assign stopDet  = r_ff.sclS & ~r_ff.sdaP & r_ff.sdaS;
  assign wrEn    = psel & penable & pwrite;
  assign rdEn    = psel & penable & ~pwrite;

  // Level to put on the data line in the low half of the current bit
  always_comb begin
    if (r_ff.bitCnt != 4'h8) begin
      bitVal = txMode ? r_ff.sh[7] : 1'b1;
    end else begin
      bitVal = txMode ? 1'b1 : lastRx;
    end
  end

  always_comb begin
    status = '0;
    status[`TBM_SR_RX_READY_FLAG]   = r_ff.rxValid;
    status[`TBM_SR_TX_READY_FLAG]   = ~r_ff.txValid;
    status[`TBM_SR_CMD_SLOT_READY]    = ~r_ff.cmd.valid | ~r_ff.ncmd.valid;
    status[`TBM_SR_COMMAND_DONE_FLAG]   = r_ff.command_done_flag;
    status[`TBM_SR_BUS_IDLE_FLAG] = ~r_ff.busy;
    status[`TBM_SR_ADDR_NACK_FLAG]    = r_ff.addr_nack_flag;
    status[`TBM_SR_DATA_NACK_FLAG]    = r_ff.data_nack_flag;
    status[`TBM_SR_ARB_LOST_FLAG]  = r_ff.arbl;
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    case (paddr)
      `TBM_OFF_CTRL: rdMux[`TBM_CTRL_EN] = r_ff.en;
      `TBM_OFF_CWG:  rdMux = r_ff.cwg;
      `TBM_OFF_CMD:  rdMux = cmdEncode(r_ff.cmd);
      `TBM_OFF_NCMD: rdMux = cmdEncode(r_ff.ncmd);
      `TBM_OFF_RHR:  rdMux[7:0] = r_ff.rx_holding_reg;
      `TBM_OFF_SR:   rdMux[`TBM_SR_W-1:0] = status;
      `TBM_OFF_IMR:  rdMux[`TBM_SR_W-1:0] = r_ff.imr;
      default:       rdMux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_r = r_ff;
    nxt_r.sclM = sclIn;
    nxt_r.sclS = r_ff.sclM;
    nxt_r.sdaM = sdaIn;
    nxt_r.sdaS = r_ff.sdaM;
    nxt_r.sdaP = r_ff.sdaS;
    nxt_r.pre  = tick ? 9'h000 : r_ff.pre + 9'h001;
    if (startDet) begin
      nxt_r.busy = 1'b1;
    end
    if (stopDet) begin
      nxt_r.busy = 1'b0;
    end

    // Software clears first, so a hardware set in the same cycle wins
    if (rdEn && paddr == `TBM_OFF_RHR) begin
      nxt_r.rxValid = 1'b0;
    end
    if (wrEn && paddr == `TBM_OFF_SCR) begin
      if (pwdata[`TBM_SR_COMMAND_DONE_FLAG]) nxt_r.command_done_flag = 1'b0;
      if (pwdata[`TBM_SR_ADDR_NACK_FLAG]) nxt_r.addr_nack_flag = 1'b0;
      if (pwdata[`TBM_SR_DATA_NACK_FLAG]) nxt_r.data_nack_flag = 1'b0;
      if (pwdata[`TBM_SR_ARB_LOST_FLAG]) nxt_r.arbl = 1'b0;
    end
    if (wrEn && paddr == `TBM_OFF_IER) begin
      nxt_r.imr = r_ff.imr | pwdata[`TBM_SR_W-1:0];
    end
    if (wrEn && paddr == `TBM_OFF_IDR) begin
      nxt_r.imr = r_ff.imr & ~pwdata[`TBM_SR_W-1:0];
    end
    if (wrEn && paddr == `TBM_OFF_CWG) begin
      nxt_r.cwg = pwdata;
    end
    if (wrEn && paddr == `TBM_OFF_CTRL) begin
      nxt_r.en = pwdata[`TBM_CTRL_EN];
    end

    case (r_ff.st)
      S_IDLE: begin
        nxt_r.sclOen = 1'b1;
        nxt_r.sdaOen = 1'b1;
        if (r_ff.en && r_ff.cmd.valid && r_ff.cmd.start && !errs && !r_ff.busy) begin
          nxt_r.sh     = {r_ff.cmd.target_address, r_ff.cmd.read};
          nxt_r.addrPh = 1'b1;
          nxt_r.cnt    = '0;
          nxt_r.st     = S_START;
        end
      end
      S_START: begin
        nxt_r.sclOen = 1'b1;
        nxt_r.sdaOen = 1'b1;
        if (r_ff.sclS && r_ff.sdaS && tick) begin
          if (r_ff.cnt == stastoT) begin
            nxt_r.sdaOen = 1'b0;
            nxt_r.cnt    = '0;
            nxt_r.st     = S_STHOLD;
          end else begin
            nxt_r.cnt = r_ff.cnt + 10'h001;
          end
        end
      end
      S_STHOLD: begin
        if (tick) begin
          if (r_ff.cnt == stastoT) begin
            nxt_r.sclOen = 1'b0;
            nxt_r.cnt    = '0;
            nxt_r.bitCnt = 4'h0;
            nxt_r.st     = S_LOW;
          end else begin
            nxt_r.cnt = r_ff.cnt + 10'h001;
          end
        end
      end
      S_LOW: begin
        nxt_r.sclOen = 1'b0;
        if (!r_ff.addrPh && r_ff.bitCnt == 4'h0 && !r_ff.gotByte) begin
          // Clock held low until the holding registers allow the byte
          if (!r_ff.cmd.read && r_ff.txValid) begin
            nxt_r.sh      = r_ff.tx_holding_reg;
            nxt_r.txValid = 1'b0;
            nxt_r.gotByte = 1'b1;
          end else if (r_ff.cmd.read && !r_ff.rxValid) begin
            nxt_r.gotByte = 1'b1;
          end
        end else if (!r_ff.sclS && tick) begin
          if (r_ff.cnt == dataT) begin
            nxt_r.sdaOen = bitVal;
          end
          if (r_ff.cnt == lowEnd) begin
            nxt_r.sclOen = 1'b1;
            nxt_r.cnt    = '0;
            nxt_r.st     = S_HIGH;
          end else begin
            nxt_r.cnt = r_ff.cnt + 10'h001;
          end
        end
      end
      S_HIGH: begin
        nxt_r.sclOen = 1'b1;
        if (r_ff.sclS) begin
          if (txMode && r_ff.bitCnt != 4'h8 && r_ff.sdaOen && !r_ff.sdaS) begin
            nxt_r.arbl   = 1'b1;
            nxt_r.sdaOen = 1'b1;
            nxt_r.st     = S_ARBW;
          end else if (tick) begin
            if (r_ff.cnt != highT) begin
              nxt_r.cnt = r_ff.cnt + 10'h001;
            end else begin
              nxt_r.cnt = '0;
              nxt_r.st  = S_LOW;
              if (r_ff.bitCnt != 4'h8) begin
                nxt_r.sh     = {r_ff.sh[6:0], r_ff.sdaS};
                nxt_r.bitCnt = r_ff.bitCnt + 4'h1;
              end else begin
                nxt_r.bitCnt  = 4'h0;
                nxt_r.gotByte = 1'b0;
                if (txMode && r_ff.sdaS) begin
                  if (r_ff.addrPh) begin
                    nxt_r.addr_nack_flag = 1'b1;
                  end else begin
                    nxt_r.data_nack_flag = 1'b1;
                  end
                  nxt_r.st = S_STOPL;
                end else begin
                  nxt_r.addrPh = 1'b0;
                  if (!r_ff.addrPh) begin
                    nxt_r.cmd.byte_count = r_ff.cmd.byte_count - 8'h01;
                    if (r_ff.cmd.read) begin
                      nxt_r.rx_holding_reg     = r_ff.sh;
                      nxt_r.rxValid = 1'b1;
                    end
                  end
                  if (r_ff.addrPh ? (r_ff.cmd.byte_count == 8'h00) : lastRx) begin
                    nxt_r.command_done_flag     = 1'b1;
                    nxt_r.cmd.valid = 1'b0;
                    nxt_r.st        = r_ff.cmd.stop ? S_STOPL : S_HOLD;
                  end
                end
              end
            end
          end
        end
      end
      S_HOLD: begin
        nxt_r.sclOen = 1'b0;
        if (r_ff.cmd.valid && !errs) begin
          if (r_ff.cmd.start) begin
            nxt_r.cnt = '0;
            nxt_r.st  = S_RSTAL;
          end else if (r_ff.cmd.byte_count == 8'h00) begin
            nxt_r.command_done_flag     = 1'b1;
            nxt_r.cmd.valid = 1'b0;
            nxt_r.st        = r_ff.cmd.stop ? S_STOPL : S_HOLD;
          end else begin
            nxt_r.st = S_LOW;
          end
        end
      end
      S_RSTAL: begin
        nxt_r.sclOen = 1'b0;
        if (!r_ff.sclS && tick) begin
          if (r_ff.cnt == dataT) begin
            nxt_r.sdaOen = 1'b1;
          end
          if (r_ff.cnt == lowEnd) begin
            nxt_r.sclOen = 1'b1;
            nxt_r.sh     = {r_ff.cmd.target_address, r_ff.cmd.read};
            nxt_r.addrPh = 1'b1;
            nxt_r.cnt    = '0;
            nxt_r.st     = S_START;
          end else begin
            nxt_r.cnt = r_ff.cnt + 10'h001;
          end
        end
      end
      S_STOPL: begin
        nxt_r.sclOen = 1'b0;
        if (!r_ff.sclS && tick) begin
          if (r_ff.cnt == dataT) begin
            nxt_r.sdaOen = 1'b0;
          end
          if (r_ff.cnt == lowEnd) begin
            nxt_r.sclOen = 1'b1;
            nxt_r.cnt    = '0;
            nxt_r.st     = S_STOPH;
          end else begin
            nxt_r.cnt = r_ff.cnt + 10'h001;
          end
        end
      end
      S_STOPH: begin
        nxt_r.sclOen = 1'b1;
        if (r_ff.sclS && tick) begin
          if (r_ff.cnt == stastoT) begin
            nxt_r.sdaOen = 1'b1;
            nxt_r.cnt    = '0;
            nxt_r.st     = S_BUF;
          end else begin
            nxt_r.cnt = r_ff.cnt + 10'h001;
          end
        end
      end
      S_BUF: begin
        if (tick) begin
          if (r_ff.cnt == lowT) begin
            nxt_r.cnt = '0;
            nxt_r.st  = S_IDLE;
          end else begin
            nxt_r.cnt = r_ff.cnt + 10'h001;
          end
        end
      end
      S_ARBW: begin
        nxt_r.sclOen = 1'b1;
        nxt_r.sdaOen = 1'b1;
        if (!r_ff.busy) begin
          nxt_r.addrPh  = 1'b0;
          nxt_r.bitCnt  = 4'h0;
          nxt_r.gotByte = 1'b0;
          nxt_r.st      = S_IDLE;
        end
      end
      default: begin
        nxt_r.st = S_IDLE;
      end
    endcase

    // Software writes that the engine must not overwrite in the same cycle
    if (wrEn && paddr == `TBM_OFF_THR) begin
      nxt_r.tx_holding_reg     = pwdata[7:0];
      nxt_r.txValid = 1'b1;
    end
    if (wrEn && paddr == `TBM_OFF_CMD) begin
      nxt_r.cmd = cmdDecode(pwdata);
    end
    if (wrEn && paddr == `TBM_OFF_NCMD) begin
      nxt_r.ncmd = cmdDecode(pwdata);
    end
    if (!nxt_r.cmd.valid && nxt_r.ncmd.valid) begin
      nxt_r.cmd        = nxt_r.ncmd;
      nxt_r.ncmd.valid = 1'b0;
    end

    if (psel && !penable) begin
      nxt_r.prdata = rdMux;
    end
    nxt_r.irq = |(status & r_ff.imr);

    if (wrEn && paddr == `TBM_OFF_CTRL && pwdata[`TBM_CTRL_SWRST]) begin
      nxt_r.st      = S_IDLE;
      nxt_r.cnt     = '0;
      nxt_r.bitCnt  = 4'h0;
      nxt_r.addrPh  = 1'b0;
      nxt_r.gotByte = 1'b0;
      nxt_r.sclOen  = 1'b1;
      nxt_r.sdaOen  = 1'b1;
      nxt_r.cmd     = '0;
      nxt_r.ncmd    = '0;
      nxt_r.txValid = 1'b0;
      nxt_r.rxValid = 1'b0;
      nxt_r.command_done_flag   = 1'b0;
      nxt_r.addr_nack_flag    = 1'b0;
      nxt_r.data_nack_flag    = 1'b0;
      nxt_r.arbl    = 1'b0;
      nxt_r.busy    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      r_ff        <= '0;
      r_ff.st     <= S_IDLE;
      r_ff.sclOen <= 1'b1;
      r_ff.sdaOen <= 1'b1;
      r_ff.sclM   <= 1'b1;
      r_ff.sclS   <= 1'b1;
      r_ff.sdaM   <= 1'b1;
      r_ff.sdaS   <= 1'b1;
      r_ff.sdaP   <= 1'b1;
      r_ff.cwg    <= `TBM_RST_CWG;
      r_ff.imr    <= `TBM_RST_IMR;
    end else begin
      r_ff <= nxt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata   = r_ff.prdata;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~regKnown(paddr);
  assign sclOut   = 1'b0;
  assign sdaOut   = 1'b0;
  assign sclOen   = r_ff.sclOen;
  assign sdaOen   = r_ff.sdaOen;
  assign dmaTxReq = ~r_ff.txValid;
  assign dmaRxReq = r_ff.rxValid;
  assign irq      = r_ff.irq;

endmodule : tbm_two_wire_master

/* tb/tbm_slave_model.sv */
/* Behavioural slave on the two-wire bus: acks writes, serves 8'hA5 on reads.
   Assumes pulled-up lines built by the bench from all enables. */
`timescale 1ns/1ps
module tbm_slave_model (
  // Bus lines
  input  wire logic sclLine,
  input  wire logic sdaLine,
  // Test control and data line drive
  input  wire logic nackAddr,
  output logic      sdaDrv
);
  logic [7:0] sh, bytes[$];
  logic [3:0] cnt;
  logic       rd, first, acks[$];
  int         starts = 0;
  initial sdaDrv = 1'b1;
  always @(negedge sdaLine) if (sclLine) begin
    cnt = 0;
    first = 1;
    rd = 0;
    starts++;
  end
  always @(posedge sclLine) begin
    if (cnt < 8) sh = {sh[6:0], sdaLine};
    else if (rd && !first) acks.push_back(sdaLine);
    cnt++;
  end
  always @(negedge sclLine) begin
    if (cnt == 9) begin
      cnt = 0;
      first = 0;
      sdaDrv = rd ? 1'(8'hA5 >> 7) : 1'b1;
    end else if (cnt == 8 && !(rd && !first)) begin
      bytes.push_back(sh);
      if (first) rd = sh[0];
      sdaDrv = first ? nackAddr : 1'b0;
    end else if (rd && !first) sdaDrv = (cnt < 8) ? 8'hA5 >> (7 - cnt) : 1'b1;
  end
endmodule : tbm_slave_model

/* tb/tbm_two_wire_master_chk.sv */
/* Checker of the two-wire master ports. Assumes bind onto the top module. */
`timescale 1ns/1ps
`include "tbm_regs.svh"
module tbm_two_wire_master_chk
  import tbm_pkg::*;
(
  // Top ports except prdata, pready and pslverr
  input wire logic ref_clk, reset_n, psel, penable, pwrite, sclIn, sdaIn,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic sclOut, sclOen, sdaOut, sdaOen, dmaTxReq, dmaRxReq, irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [31:0] cwg_ff;
  logic [10:0] msk_ff;
  logic [15:0] loCnt_ff, hiCnt_ff, tick;
  wire wr = psel && penable && pwrite;
  assign tick = 16'h1 << ({1'b0, cwg_ff[30:28]} + 4'h1);
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cwg_ff <= '0;
      msk_ff <= '0;
      loCnt_ff <= '0;
      hiCnt_ff <= '0;
    end else begin
      if (wr && paddr == `TBM_OFF_CWG) cwg_ff <= pwdata;
      if (wr && paddr == `TBM_OFF_IER) msk_ff <= msk_ff | pwdata[10:0];
      if (wr && paddr == `TBM_OFF_IDR) msk_ff <= msk_ff & ~pwdata[10:0];
      loCnt_ff <= sclOen ? 16'h0 : loCnt_ff + 16'h1;
      hiCnt_ff <= (sclOen && sclIn) ? hiCnt_ff + 16'h1 : 16'h0;
    end
  end
  sequence stretched; $rose(sclOen) ##1 (!sclIn) [*3]; endsequence
  open_drain_a: assert property (!sclOut && !sdaOut) else $error("line driven high");
  low_time_a: assert property ($rose(sclOen) |-> loCnt_ff >=
    (2 * cwg_ff[27:24] + cwg_ff[7:0] + 1) * tick) else $error("clock low short");
  high_time_a: assert property ($fell(sclOen) |-> hiCnt_ff >=
    (cwg_ff[15:8] + 1) * tick) else $error("clock high short");
  sda_edge_a: assert property ($changed(sdaOen) && sclOen |-> $past(sclIn, 2))
    else $error("data moved under low clock");
  stretch_wait_a: assert property (stretched |-> sclOen && $stable(sdaOen))
    else $error("stretch not honoured");
  tx_req_a: assert property (wr && paddr == `TBM_OFF_THR |=> !dmaTxReq)
    else $error("tx request stayed");
  rx_req_a: assert property (psel && penable && !pwrite && paddr == `TBM_OFF_RHR
    |=> !dmaRxReq) else $error("rx request stayed");
  irq_mask_a: assert property (msk_ff == 0 && $past(msk_ff) == 0 |-> !irq)
    else $error("irq while masked");
endmodule : tbm_two_wire_master_chk
bind tbm_two_wire_master tbm_two_wire_master_chk chk (.*);

/* tb/tbm_two_wire_master_test.sv */
/* Self-checking bench of the two-wire master. Assumes the slave model. */
`timescale 1ns/1ps
`include "tbm_regs.svh"
module tbm_two_wire_master_test;
  typedef struct packed { logic [7:0] a; logic [31:0] e; } tbm_row_t;
  logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic sclHold = 0, nackAddr = 0, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, r;
  wire [31:0] prdata;
  wire pready, pslverr, sclOut, sclOen, sdaOut, sdaOen, dmaTxReq, dmaRxReq, irq, sdaDrv;
  wire sclLine = sclOen & ~sclHold;
  wire sdaLine = sdaOen & sdaDrv;
  int mismatches = 0, total_checks = 0, n0;
  tbm_row_t rows[6] = '{'{8'h04, 0}, '{8'h24, 0}, '{8'h18, 32'h16}, '{8'h14, 0},
                        '{8'h08, 0}, '{8'h2C, 0}};
  always #2.5 ref_clk = ~ref_clk;
  tbm_two_wire_master uut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclIn(sclLine), .sclOut(sclOut), .sclOen(sclOen),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOen(sdaOen), .dmaTxReq(dmaTxReq),
    .dmaRxReq(dmaRxReq), .irq(irq));
  tbm_slave_model slv (.sclLine(sclLine), .sdaLine(sdaLine), .nackAddr(nackAddr),
    .sdaDrv(sdaDrv));
  task results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
    r = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 20) begin mismatches++; results; end
  endtask : apb
  task waitSr(input int b, input logic v);
    int i;
    for (i = 0; i < 500; i++) begin apb(0, `TBM_OFF_SR, 0); if (r[b] === v) break; end
    if (i >= 500) begin mismatches++; results; end
  endtask : waitSr
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      apb(0, rows[i].a, 0);
      chk("reset read", r, rows[i].e);
      chk("slverr", {31'h0, err}, {31'h0, rows[i].a == 8'h2C});
    end
    apb(1, `TBM_OFF_CWG, 32'h0102_0202);
    apb(1, `TBM_OFF_CTRL, 1);
    apb(1, `TBM_OFF_IER, 8);
    apb(1, `TBM_OFF_THR, 8'h3C);
    apb(1, `TBM_OFF_CMD, 32'h0002_E0AA);
    repeat (40) @(posedge ref_clk);
    for (int i = 0; i < 50 && sclOen !== 1'b0; i++) @(posedge ref_clk);
    if (sclOen !== 1'b0) begin mismatches++; results; end
    sclHold <= 1'b1;
    repeat (40) @(posedge ref_clk);
    sclHold <= 1'b0;
    waitSr(1, 1);
    apb(1, `TBM_OFF_THR, 8'hC3);
    waitSr(3, 1);
    chk("irq set", irq, 1);
    waitSr(4, 1);
    chk("bytes", {slv.bytes[0], slv.bytes[1], slv.bytes[2]}, 24'hAA3CC3);
    chk("tx req", dmaTxReq, 1);
    apb(1, `TBM_OFF_SCR, 8);
    repeat (3) @(posedge ref_clk);
    chk("irq clear", irq, 0);
    apb(1, `TBM_OFF_IDR, 8);
    apb(0, `TBM_OFF_IMR, 0);
    chk("mask off", r, 0);
    slv.bytes.delete();
    apb(1, `TBM_OFF_CMD, 32'h0002_E0AB);
    repeat (2) begin waitSr(0, 1); apb(0, `TBM_OFF_RHR, 0); chk("rhr", r, 8'hA5); end
    waitSr(4, 1);
    chk("read addr", slv.bytes[0], 8'hAB);
    chk("acks", {slv.acks[0], slv.acks[1]}, 2'b01);
    apb(1, `TBM_OFF_SCR, 8);
    slv.bytes.delete();
    apb(1, `TBM_OFF_CMD, 32'h0000_E0AA);
    waitSr(3, 1);
    waitSr(4, 1);
    chk("zero bytes", slv.bytes.size(), 1);
    nackAddr <= 1'b1;
    n0 = slv.starts;
    apb(1, `TBM_OFF_CMD, 32'h0001_E0AA);
    waitSr(8, 1);
    chk("addr nack", r[10:8], 3'b001);
    waitSr(4, 1);
    apb(0, `TBM_OFF_CMD, 0);
    chk("valid kept", r[15], 1);
    repeat (300) @(posedge ref_clk);
    chk("no restart", slv.starts - n0, 1);
    apb(1, `TBM_OFF_NCMD, 32'h0000_E0AA);
    apb(0, `TBM_OFF_SR, 0);
    chk("slot full", r[2], 0);
    apb(1, `TBM_OFF_CMD, 0);
    apb(0, `TBM_OFF_CMD, 0);
    chk("next copied", r, 32'h0000_E0AA);
    nackAddr <= 1'b0;
    apb(1, `TBM_OFF_SCR, 32'h108);
    waitSr(3, 1);
    waitSr(4, 1);
    chk("resumed", slv.starts - n0, 2);
    apb(1, `TBM_OFF_THR, 32'h5A);
    apb(0, `TBM_OFF_SR, 0);
    chk("thr full", {r[1], dmaTxReq}, 0);
    apb(1, `TBM_OFF_CTRL, 32'h81);
    apb(0, `TBM_OFF_SR, 0);
    chk("soft reset", r, 32'h16);
    chk("tx req free", dmaTxReq, 1);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    chk("lines free", {sclOen, sdaOen, irq}, 3'b110);
    apb(0, `TBM_OFF_CWG, 0);
    chk("cwg reset", r, 0);
    results;
  end
endmodule : tbm_two_wire_master_test
